//--- hdl/plw_counter.sv
`timescale 1ns/1ns
module plw_counter #(
  parameter int CNT_W = plw_pkg::PLW_CNT_W
) (
  input  wire logic             i_clk_sys, // system clock
  input  wire logic             i_srst,    // sync reset
  input  wire logic             i_tick,    // count enable tick
  input  wire logic             i_clr,     // clear counter
  input  wire logic             i_use_xt,  // crystal period table
  input  wire logic [2:0]       i_period,  // period select
  output logic      [CNT_W-1:0] o_count,   // counter value
  output logic                  o_ovf      // overflow pulse
);

  logic [4:0]       top_idx;
  logic [CNT_W-1:0] mask;

  // ---------------------------------------------------------------
  // period decode
  // ---------------------------------------------------------------
  // highest bit index of the selected period
  assign top_idx = (i_use_xt ? plw_pkg::PLW_XT_EXP_MIN : plw_pkg::PLW_LS_EXP_MIN)
                   + {2'b00, i_period} - 5'd1;

  // ones up to the top bit
  for (genvar g = 0; g < CNT_W; g++) begin : g_mask
    assign mask[g] = (5'(g) <= top_idx);
  end

  // overflow when the low bits are all ones on a tick
  assign o_ovf = i_tick && ((o_count & mask) == mask);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // free-running, clear wins over a tick
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_clr) begin
      o_count <= '0;
    end else if (i_tick) begin
      o_count <= o_count + CNT_W'(1);
    end
  end

endmodule // plw_counter

//--- hdl/plw_pkg.sv
package plw_pkg;

  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] PLW_OFS_MODE    = 8'h98; // watchdog_mode_register
  localparam logic [7:0] PLW_OFS_RESTART = 8'h99; // watchdog_restart_register
  localparam logic [7:0] PLW_OFS_CAUSE   = 8'ha0; // reset_cause_register
  localparam logic [7:0] PLW_OFS_STAT    = 8'ha1; // interrupt status, write one to clear
  localparam logic [7:0] PLW_OFS_MASK    = 8'ha2; // interrupt mask

  // -----------------------------------------------------------------
  // values and field positions
  // -----------------------------------------------------------------
  localparam logic [7:0] PLW_MODE_RST    = 8'h67; // mode register after reset
  localparam logic [2:0] PLW_MODE_FIXED  = 3'h3;  // bits 7:5 always read 011
  localparam logic [1:0] PLW_CS_RST      = 2'h0;  // low-speed clock
  localparam logic [2:0] PLW_PS_RST      = 3'h7;  // longest period
  localparam logic [7:0] PLW_RESTART_KEY = 8'hac; // restart code
  localparam logic [7:0] PLW_RESTART_RD  = 8'h9a; // restart register read value
  localparam int         PLW_CAUSE_BIT   = 4;     // watchdog reset cause bit
  localparam int         PLW_EV_W        = 3;     // interrupt event count
  localparam int         PLW_EV_OVF      = 0;     // counter overflow
  localparam int         PLW_EV_RESTART  = 1;     // accepted restart
  localparam int         PLW_EV_ILLEGAL  = 2;     // illegal access
  localparam logic [4:0] PLW_LS_EXP_MIN  = 5'd11; // low-speed shortest exponent
  localparam logic [4:0] PLW_XT_EXP_MIN  = 5'd13; // crystal shortest exponent
  localparam int         PLW_CNT_W       = 20;    // counter width

  // -----------------------------------------------------------------
  // clock source
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLW_SRC_LS,
    PLW_SRC_XT,
    PLW_SRC_OFF
  } plw_src_t;

  // clock-select field to source
  function automatic plw_src_t plw_decode_src(input logic [1:0] cs);
    plw_src_t s;
    s = PLW_SRC_LS;
    if (cs[1]) begin
      s = PLW_SRC_OFF;
    end else if (cs[0]) begin
      s = PLW_SRC_XT;
    end
    return s;
  endfunction

endpackage

//--- hdl/plw_tick_gate.sv
`timescale 1ns/1ns
module plw_tick_gate (
  input  wire logic              i_fixed,      // low-speed oscillator cannot stop
  input  wire plw_pkg::plw_src_t i_src,        // selected source
  input  wire logic              i_ls_tick,    // low-speed clock tick
  input  wire logic              i_xt_tick,    // crystal clock tick
  input  wire logic              i_xt_stopped, // crystal clock stopped
  input  wire logic              i_cpu_pause,  // cpu pause mode
  input  wire logic              i_deep_sleep, // deep sleep mode
  input  wire logic              i_osc_stab,   // oscillation stabilisation wait
  input  wire logic              i_cpu_on_xt,  // cpu runs on crystal clock
  input  wire logic              i_sw_ls_stop, // software stopped low-speed osc
  output logic                   o_tick        // gated counter tick
);

  // ---------------------------------------------------------------
  // tick selection and gating
  // ---------------------------------------------------------------
  // fixed mode never gates the low-speed tick
  always_comb begin
    o_tick = 1'b0;
    if (i_fixed) begin
      o_tick = i_ls_tick;
    end else begin
      unique case (i_src)
        plw_pkg::PLW_SRC_XT: begin
          o_tick = i_xt_tick && !i_xt_stopped && !i_cpu_pause
                   && !i_deep_sleep && !i_osc_stab;
        end
        plw_pkg::PLW_SRC_LS: begin
          o_tick = i_ls_tick && !i_cpu_pause && !i_deep_sleep
                   && !(i_cpu_on_xt && i_sw_ls_stop);
        end
        default: begin
          o_tick = 1'b0; // stopped source
        end
      endcase
    end
  end

endmodule // plw_tick_gate

//--- hdl/plw_top.sv
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
// Contract
// - overflow raises internal chip reset
// - watchdog reset sets cause bit 4
// - low-speed period 2^11 to 2^18
// - crystal period 2^13 to 2^20
// - option setting picks watchdog mode
// - fixed mode: low-speed clock, never stops
// - stoppable mode: crystal, low-speed or stopped
// - start at reset: low-speed, longest period
// - fixed mode: period changeable once
// - stoppable mode: source and period once
// - crystal tick gated in pause, sleep, stabilise
// - low-speed tick gated in pause, sleep
// - fixed mode oscillator runs except reset
// - restart with ac; else reset; reads 9a
// - second mode write causes reset
// - mode resets to 67, field layout
// - mode write clears counter; fixed ignores select
module plw_top #(
  parameter int CNT_W = plw_pkg::PLW_CNT_W
) (
  input  wire logic       i_clk_sys,     // system clock, 10 MHz
  input  wire logic       i_srst,        // sync reset, active high
  input  wire logic       i_por,         // power-on reset, clears cause flag
  input  wire logic       i_opt_ls_fixed,// option: low-speed osc cannot stop
  input  wire logic       i_ls_tick,     // low-speed clock tick
  input  wire logic       i_xt_tick,     // crystal clock tick
  input  wire logic       i_xt_stopped,  // crystal clock stopped
  input  wire logic       i_cpu_pause,   // cpu pause mode
  input  wire logic       i_deep_sleep,  // deep sleep mode
  input  wire logic       i_osc_stab,    // oscillation stabilisation wait
  input  wire logic       i_cpu_on_xt,   // cpu runs on crystal clock
  input  wire logic       i_sw_ls_stop,  // software low-speed osc stop
  input  wire logic [7:0] i_addr,        // register address
  input  wire logic [7:0] i_wdata,       // write data
  input  wire logic       i_wr,          // write strobe
  input  wire logic       i_rd,          // read strobe
  input  wire logic       i_bitop,       // write is a single-bit operation
  output logic      [7:0] o_rdata,       // read data, cycle after strobe
  output logic            o_int_reset,   // internal reset request
  output logic            o_irq,         // interrupt, level
  output logic            o_ls_osc_run   // low-speed oscillator enable
);

  logic                         fixed_reg;
  logic [1:0]                   cs_reg;
  logic [2:0]                   ps_reg;
  logic                         written_reg;
  logic                         rst_req_reg;
  logic                         cause_reg;
  logic [plw_pkg::PLW_EV_W-1:0] stat_reg;
  logic [plw_pkg::PLW_EV_W-1:0] mask_reg;
  logic [plw_pkg::PLW_EV_W-1:0] ev;
  logic [7:0]                   rdata_reg;
  logic [7:0]                   mode_val;
  logic [CNT_W-1:0]             count;
  logic                         hit_mode;
  logic                         hit_rst;
  logic                         mode_acc;
  logic                         mode_bad;
  logic                         rst_good;
  logic                         rst_bad;
  logic                         ovf;
  logic                         tick;
  plw_pkg::plw_src_t            src;

  // -----------------------------------------------------------------
  // address decode and access classes
  // -----------------------------------------------------------------
  assign hit_mode = (i_addr == plw_pkg::PLW_OFS_MODE);
  assign hit_rst  = (i_addr == plw_pkg::PLW_OFS_RESTART);
  // first full-byte write of the mode register
  assign mode_acc = i_wr && hit_mode && !i_bitop && !written_reg;
  // any later write attempt
  assign mode_bad = i_wr && hit_mode && written_reg;
  assign rst_good = i_wr && hit_rst && !i_bitop
                    && (i_wdata == plw_pkg::PLW_RESTART_KEY);
  assign rst_bad  = i_wr && hit_rst
                    && (i_bitop || (i_wdata != plw_pkg::PLW_RESTART_KEY));
  assign mode_val = {plw_pkg::PLW_MODE_FIXED, cs_reg, ps_reg};

  // -----------------------------------------------------------------
  // option capture
  // -----------------------------------------------------------------
  // mode option latched while reset is held
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      fixed_reg <= i_opt_ls_fixed;
    end
  end

  // oscillator stays on in fixed mode, off only in reset
  assign o_ls_osc_run = !i_srst && (fixed_reg || !i_sw_ls_stop);

  // -----------------------------------------------------------------
  // mode register, write once
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cs_reg      <= plw_pkg::PLW_CS_RST;
      ps_reg      <= plw_pkg::PLW_PS_RST;
      written_reg <= 1'b0;
    end else if (mode_acc) begin
      written_reg <= 1'b1;
      ps_reg      <= i_wdata[2:0];
      // select bits ignored in fixed mode
      cs_reg      <= fixed_reg ? plw_pkg::PLW_CS_RST : i_wdata[4:3];
    end
  end

  // -----------------------------------------------------------------
  // clock source, gating and counter
  // -----------------------------------------------------------------
  assign src = plw_pkg::plw_decode_src(fixed_reg ? plw_pkg::PLW_CS_RST : cs_reg);

  plw_tick_gate u_gate (
    .i_fixed      (fixed_reg),
    .i_src        (src),
    .i_ls_tick    (i_ls_tick),
    .i_xt_tick    (i_xt_tick),
    .i_xt_stopped (i_xt_stopped),
    .i_cpu_pause  (i_cpu_pause),
    .i_deep_sleep (i_deep_sleep),
    .i_osc_stab   (i_osc_stab),
    .i_cpu_on_xt  (i_cpu_on_xt),
    .i_sw_ls_stop (i_sw_ls_stop),
    .o_tick       (tick)
  );

  // restart and mode write both clear the count
  plw_counter #(
    .CNT_W (CNT_W)
  ) u_cnt (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_tick    (tick),
    .i_clr     (rst_good || mode_acc),
    .i_use_xt  (src == plw_pkg::PLW_SRC_XT),
    .i_period  (ps_reg),
    .o_count   (count),
    .o_ovf     (ovf)
  );

  // -----------------------------------------------------------------
  // internal reset request and cause flag
  // -----------------------------------------------------------------
  // held until the system reset comes back
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rst_req_reg <= 1'b0;
    end else if (ovf || rst_bad || mode_bad) begin
      rst_req_reg <= 1'b1;
    end
  end
  assign o_int_reset = rst_req_reg;

  // survives the reset it caused; set wins over a write clear, power-on reset wins over set
  always_ff @(posedge i_clk_sys) begin
    if (i_por) begin
      cause_reg <= 1'b0;
    end else if (rst_req_reg) begin
      cause_reg <= 1'b1;
    end else if (!i_srst && i_wr && !i_bitop && (i_addr == plw_pkg::PLW_OFS_CAUSE)
                 && i_wdata[plw_pkg::PLW_CAUSE_BIT]) begin
      cause_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // interrupt status and mask
  // -----------------------------------------------------------------
  assign ev[plw_pkg::PLW_EV_OVF]     = ovf;
  assign ev[plw_pkg::PLW_EV_RESTART] = rst_good;
  assign ev[plw_pkg::PLW_EV_ILLEGAL] = rst_bad || mode_bad;

  // sticky bits, write one clears, event wins
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      stat_reg <= '0;
    end else if (i_wr && (i_addr == plw_pkg::PLW_OFS_STAT)) begin
      stat_reg <= (stat_reg & ~i_wdata[plw_pkg::PLW_EV_W-1:0]) | ev;
    end else begin
      stat_reg <= stat_reg | ev;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mask_reg <= '0;
    end else if (i_wr && (i_addr == plw_pkg::PLW_OFS_MASK)) begin
      mask_reg <= i_wdata[plw_pkg::PLW_EV_W-1:0];
    end
  end

  assign o_irq = |(stat_reg & mask_reg);

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  // one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !i_rd) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (i_addr)
        plw_pkg::PLW_OFS_MODE:    rdata_reg <= mode_val;
        plw_pkg::PLW_OFS_RESTART: rdata_reg <= plw_pkg::PLW_RESTART_RD;
        plw_pkg::PLW_OFS_CAUSE:   rdata_reg <= 8'(cause_reg) << plw_pkg::PLW_CAUSE_BIT;
        plw_pkg::PLW_OFS_STAT:    rdata_reg <= 8'(stat_reg);
        plw_pkg::PLW_OFS_MASK:    rdata_reg <= 8'(mask_reg);
        default:                  rdata_reg <= 8'h00;
      endcase
    end
  end
  assign o_rdata = rdata_reg;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence s_good_restart;
    i_wr && hit_rst && !i_bitop && (i_wdata == 8'hac);
  endsequence
  sequence s_restart_read;
    i_rd && hit_rst;
  endsequence
  sequence s_second_write;
    i_wr && hit_mode && written_reg;
  endsequence

  property p_ovf_reset;
    ovf |=> o_int_reset [*2];
  endproperty
  a_ovf_reset: assert property (p_ovf_reset) else $error("no reset after overflow");

  property p_cause_set;
    $rose(rst_req_reg) |=> cause_reg;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause flag not set");

  property p_restart_clear;
    s_good_restart |=> (count == '0);
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart missed");

  property p_restart_read;
    s_restart_read |=> (o_rdata == 8'h9a) ##1 (o_rdata == 8'h00 || $past(i_rd));
  endproperty
  a_restart_read: assert property (p_restart_read) else $error("bad restart read");

  property p_bad_restart;
    (i_wr && hit_rst && (i_wdata != 8'hac)) |=> o_int_reset;
  endproperty
  a_bad_restart: assert property (p_bad_restart) else $error("bad restart kept");

  property p_second_write;
    s_second_write |=> o_int_reset && $stable(ps_reg);
  endproperty
  a_second_write: assert property (p_second_write) else $error("rewrite accepted");

  property p_fixed_select;
    fixed_reg |-> (cs_reg == 2'b00) && (src == plw_pkg::PLW_SRC_LS);
  endproperty
  a_fixed_select: assert property (p_fixed_select) else $error("fixed source moved");

  property p_pause_gate;
    (!fixed_reg && (i_cpu_pause || i_deep_sleep)) |-> !tick;
  endproperty
  a_pause_gate: assert property (p_pause_gate) else $error("tick in pause");

  property p_mode_clear;
    (i_wr && hit_mode && !i_bitop && !written_reg) |=> (count == '0) && written_reg;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode write missed");

  // gating, fixed-mode and stopped-source checks
  property p_xt_gate;
    (!fixed_reg && (src == plw_pkg::PLW_SRC_XT) && (i_xt_stopped || i_osc_stab)) |-> !tick;
  endproperty
  a_xt_gate: assert property (p_xt_gate) else $error("crystal tick not gated");

  property p_ls_gate;
    (!fixed_reg && (src == plw_pkg::PLW_SRC_LS) && i_cpu_on_xt && i_sw_ls_stop) |-> !tick;
  endproperty
  a_ls_gate: assert property (p_ls_gate) else $error("low-speed tick not gated");

  property p_fixed_count;
    (fixed_reg && i_ls_tick) |-> tick;
  endproperty
  a_fixed_count: assert property (p_fixed_count) else $error("fixed mode tick lost");

  property p_stopped_hold;
    ((src == plw_pkg::PLW_SRC_OFF) && !rst_good && !mode_acc) |=> $stable(count);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped counter moved");

  property p_reset_state;
    $fell(i_srst) |-> (mode_val == 8'h67) && !written_reg;
  endproperty
  a_reset_state: assert property (disable iff (1'b0) p_reset_state)
    else $error("bad mode after reset");

endmodule // plw_top

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
  // -----------------------------------------------------------------
  // bench types and signals
  // -----------------------------------------------------------------
  typedef struct {
    logic       opt;   // option: fixed low-speed mode
    logic [7:0] wdata; // mode write value
    logic [7:0] rdexp; // mode read-back
    int         ticks; // ticks to overflow, 0 = never
    int         g;     // gate condition held at start
    logic       gated; // gate should stop counting
  } plwtb_row_t;
  localparam int GATE = 500;
  logic       i_clk_sys;
  logic       i_srst;
  logic       i_por;
  logic       i_opt_ls_fixed;
  logic       i_ls_tick;
  logic       i_xt_tick;
  logic       i_xt_stopped;
  logic       i_cpu_pause;
  logic       i_deep_sleep;
  logic       i_osc_stab;
  logic       i_cpu_on_xt;
  logic       i_sw_ls_stop;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic       i_bitop;
  logic [7:0] o_rdata;
  logic       o_int_reset;
  logic       o_irq;
  logic       o_ls_osc_run;
  int         miscompares;
  int         checks;
  int         n;
  logic       done;
  plwtb_row_t rows [9];

  // device under test
  plw_top i_plw_top (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_por(i_por), .i_opt_ls_fixed(i_opt_ls_fixed),
    .i_ls_tick(i_ls_tick), .i_xt_tick(i_xt_tick), .i_xt_stopped(i_xt_stopped),
    .i_cpu_pause(i_cpu_pause), .i_deep_sleep(i_deep_sleep), .i_osc_stab(i_osc_stab),
    .i_cpu_on_xt(i_cpu_on_xt), .i_sw_ls_stop(i_sw_ls_stop), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_bitop(i_bitop), .o_rdata(o_rdata),
    .o_int_reset(o_int_reset), .o_irq(o_irq), .o_ls_osc_run(o_ls_osc_run)
  ); // plw_top

  // 10 MHz clock
  always #50 i_clk_sys = ~i_clk_sys;

  // -----------------------------------------------------------------
  // helper tasks
  // -----------------------------------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write, outputs sampled mid-cycle after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bop);
    @(posedge i_clk_sys);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    i_bitop <= bop;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
    i_bitop <= 1'b0;
    @(negedge i_clk_sys);
  endtask

  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    @(negedge i_clk_sys);
    chk(o_rdata, exp, what);
  endtask

  // hold the selected sleep or gating condition
  task automatic set_gate(input int g, input logic v);
    i_cpu_pause  <= v && g == 1;
    i_deep_sleep <= v && g == 2;
    i_osc_stab   <= v && g == 3;
    i_xt_stopped <= v && g == 4;
    i_cpu_on_xt  <= v && g == 5;
    i_sw_ls_stop <= v && g == 5;
  endtask

  // synchronous reset held over four edges
  task automatic do_reset(input logic opt, input logic por);
    @(posedge i_clk_sys);
    i_srst         <= 1'b1;
    i_por          <= por;
    i_opt_ls_fixed <= opt;
    i_ls_tick      <= 1'b0;
    i_xt_tick      <= 1'b0;
    set_gate(0, 1'b0);
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(8'({o_int_reset, o_irq, o_ls_osc_run}), 8'h00, "outputs in reset");
    @(posedge i_clk_sys);
    i_srst <= 1'b0;
    i_por  <= 1'b0;
  endtask

  // free-running ticks on both sources for a number of cycles
  task automatic tick_for(input int c);
    @(posedge i_clk_sys);
    i_ls_tick <= 1'b1;
    i_xt_tick <= 1'b1;
    repeat (c) @(posedge i_clk_sys);
    i_ls_tick <= 1'b0;
    i_xt_tick <= 1'b0;
  endtask

  // give up on a hang
  initial begin
    #9000000;
    miscompares++;
    stop_test();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0; i_srst = 1'b1; i_por = 1'b1; i_opt_ls_fixed = 1'b0;
    i_ls_tick = 1'b0; i_xt_tick = 1'b0; i_xt_stopped = 1'b0; i_cpu_pause = 1'b0;
    i_deep_sleep = 1'b0; i_osc_stab = 1'b0; i_cpu_on_xt = 1'b0; i_sw_ls_stop = 1'b0;
    i_addr = 8'h00; i_wdata = 8'h00; i_wr = 1'b0; i_rd = 1'b0; i_bitop = 1'b0;
    miscompares = 0; checks = 0;
    rows = '{'{1'b0, 8'h60, 8'h60, 2048, 0, 1'b0}, '{1'b0, 8'h68, 8'h68, 8192, 3, 1'b1},
             '{1'b0, 8'h68, 8'h68, 8192, 4, 1'b1}, '{1'b0, 8'h61, 8'h61, 4096, 1, 1'b1},
             '{1'b0, 8'h60, 8'h60, 2048, 2, 1'b1}, '{1'b0, 8'h60, 8'h60, 2048, 5, 1'b1},
             '{1'b1, 8'h68, 8'h60, 2048, 1, 1'b0}, '{1'b1, 8'h72, 8'h62, 8192, 5, 1'b0},
             '{1'b0, 8'h70, 8'h70, 0, 0, 1'b0}};
    // table rows: mode setting, gating and overflow time
    foreach (rows[k]) begin
      do_reset(rows[k].opt, k == 0);
      wr(plw_pkg::PLW_OFS_MODE, rows[k].wdata, 1'b0);
      rd(plw_pkg::PLW_OFS_MODE, rows[k].rdexp, "mode read-back");
      n = 0;
      done = 1'b0;
      @(posedge i_clk_sys);
      i_ls_tick <= 1'b1;
      i_xt_tick <= 1'b1;
      set_gate(rows[k].g, 1'b1);
      while (!done && n < (rows[k].ticks == 0 ? 9000 : rows[k].ticks + GATE + 10)) begin
        @(posedge i_clk_sys);
        if (n == GATE - 1) set_gate(rows[k].g, 1'b0);
        @(negedge i_clk_sys);
        n++;
        if (n == 1) begin
          chk({7'h0, o_ls_osc_run}, 8'(rows[k].opt || rows[k].g != 5), "osc run");
        end
        done = (o_int_reset === 1'b1);
      end
      // ticks dropped on a rising edge
      @(posedge i_clk_sys);
      i_ls_tick <= 1'b0;
      i_xt_tick <= 1'b0;
      if (rows[k].ticks == 0) begin
        chk({7'h0, done}, 8'h00, "stopped counter reset");
      end else begin
        n = n - rows[k].ticks - (rows[k].gated ? GATE : 0);
        chk(8'(n == 0), 8'h01, "ovf time");
        rd(plw_pkg::PLW_OFS_CAUSE, 8'h10, "cause after overflow");
        rd(plw_pkg::PLW_OFS_STAT, 8'h01, "overflow status");
        chk({7'h0, o_int_reset}, 8'h01, "reset held");
        // cause flag can only be cleared after the reset it asked for
        do_reset(rows[k].opt, 1'b0);
        rd(plw_pkg::PLW_OFS_CAUSE, 8'h10, "cause kept over reset");
        wr(plw_pkg::PLW_OFS_CAUSE, 8'h10, 1'b0);
        rd(plw_pkg::PLW_OFS_CAUSE, 8'h00, "cause cleared");
      end
    end
    // defaults after power-up, bit-op and second mode write
    do_reset(1'b0, 1'b1);
    rd(plw_pkg::PLW_OFS_MODE, plw_pkg::PLW_MODE_RST, "mode reset");
    rd(plw_pkg::PLW_OFS_RESTART, plw_pkg::PLW_RESTART_RD, "restart read");
    rd(8'h55, 8'h00, "unmapped read");
    rd(plw_pkg::PLW_OFS_CAUSE, 8'h00, "cause after power-up");
    wr(plw_pkg::PLW_OFS_MODE, 8'h60, 1'b1);
    rd(plw_pkg::PLW_OFS_MODE, 8'h67, "bit-op mode write");
    wr(plw_pkg::PLW_OFS_MODE, 8'h60, 1'b0);
    chk({7'h0, o_int_reset}, 8'h00, "first mode write");
    wr(plw_pkg::PLW_OFS_MODE, 8'h60, 1'b0);
    chk({7'h0, o_int_reset}, 8'h01, "second mode write");
    // restart keeps counter short of overflow
    do_reset(1'b0, 1'b0);
    rd(plw_pkg::PLW_OFS_CAUSE, 8'h10, "cause kept over reset");
    wr(plw_pkg::PLW_OFS_CAUSE, 8'h10, 1'b0);
    wr(plw_pkg::PLW_OFS_MODE, 8'h60, 1'b0);
    tick_for(1500);
    wr(plw_pkg::PLW_OFS_RESTART, plw_pkg::PLW_RESTART_KEY, 1'b0);
    tick_for(1500);
    @(negedge i_clk_sys);
    chk({7'h0, o_int_reset}, 8'h00, "restart clears counter");
    // interrupt masked, unmasked, cleared
    chk({7'h0, o_irq}, 8'h00, "irq masked");
    wr(plw_pkg::PLW_OFS_MASK, 8'h02, 1'b0);
    chk({7'h0, o_irq}, 8'h01, "irq unmasked");
    wr(plw_pkg::PLW_OFS_STAT, 8'h02, 1'b0);
    chk({7'h0, o_irq}, 8'h00, "irq cleared");
    // bit-op restart and wrong key both reset
    wr(plw_pkg::PLW_OFS_RESTART, plw_pkg::PLW_RESTART_KEY, 1'b1);
    chk({7'h0, o_int_reset}, 8'h01, "bit-op restart");
    rd(plw_pkg::PLW_OFS_STAT, 8'h04, "illegal status");
    wr(plw_pkg::PLW_OFS_MASK, 8'h04, 1'b0);
    chk({7'h0, o_irq}, 8'h01, "irq on illegal");
    do_reset(1'b0, 1'b1);
    wr(plw_pkg::PLW_OFS_RESTART, 8'h00, 1'b0);
    chk({7'h0, o_int_reset}, 8'h01, "wrong restart key");
    stop_test();
  end
endmodule // tb
